// [link_status_pkg.sv]
// constants, field layout and carriers for the link partner status bits
// assumes one pclk domain and an apb register port of 32-bit words
//
// Functional notes
// - negotiation done bit includes parallel detection
// - done bit zero if negotiation unsupported/off/non-ethernet
// - done bit exists wherever enabled bit exists
// - bit 07 set on parallel detect link
// - bit 07 clear otherwise or non-ethernet
// - bit 09 partner gigabit full duplex
// - bit 10 partner gigabit half duplex
// - bit 11 partner fast four pair
// - bit 12 partner fast full duplex
// - bit 13 partner fast half duplex
// - bit 14 partner ten full duplex
// - ability bits valid only when fully qualified
// - all ability bits 09 to 14 implemented
// - enabled bit one only while negotiation enabled
// - serdes bit one only for direct attach

package link_status_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] LIVE_OFF = 8'h04;
   localparam logic [7:0] SNAP_OFF = 8'h08;
   localparam logic [7:0] RAW_OFF = 8'h0C;

   // ------------------------------------------------------------
   // status word field positions
   // ------------------------------------------------------------
   localparam int AN_FLAG_BIT = 5;
   localparam int AN_DONE_BIT = 6;
   localparam int PAR_DET_BIT = 7;
   localparam int RSVD_BIT = 8;
   localparam int ABIL_LO_BIT = 9;
   localparam int ABIL_HI_BIT = 14;
   localparam int SERDES_BIT = 20;
   localparam int CTRL_AN_EN_BIT = 0;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic CTRL_AN_EN_RST = 1'h1;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   // partner abilities, lsb is bit 09 of the status word
   typedef struct packed {
      logic partner_ten_full;
      logic partner_fast_half;
      logic partner_fast_full;
      logic partner_fast_four_pair;
      logic partner_gig_half;
      logic partner_gig_full;
   } ability_s;

   // internal phy and negotiation state of the controller
   typedef struct packed {
      logic eth_link;
      logic an_capable;
      logic an_done;
      logic par_det;
      logic serdes_direct;
      ability_s ability;
   } phy_state_s;

   // ability bits carry meaning only under all four qualifiers
   function automatic logic ability_valid(input logic eth, input logic serdes, input logic an_flag,
                                          input logic an_done);
      ability_valid = eth & ~serdes & an_flag & an_done;
   endfunction : ability_valid

endpackage : link_status_pkg

// [link_status_word.sv]
// builds the qualified status word bits 05..14 and 20 each pclk
// assumes phy state inputs are synchronous to pclk

module link_status_word
   import link_status_pkg::*;
(
   input wire logic pclk, // controller clock
   input wire logic presetn, // async reset, active low
   input wire phy_state_s phy, // raw phy and negotiation state
   input wire logic an_en, // negotiation enabled by software
   output logic [31:0] word_q // qualified status word
);

   // ------------------------------------------------------------
   // qualification
   // ------------------------------------------------------------
   logic an_flag;
   logic an_done;
   logic par_det;
   logic abil_ok;
   logic [5:0] abil_out;
   logic [31:0] word_d;

   // enabled only when supported, switched on and ethernet
   assign an_flag = phy.eth_link & phy.an_capable & an_en;
   // parallel detection also counts as completion
   assign an_done = an_flag & (phy.an_done | phy.par_det);
   assign par_det = phy.eth_link & phy.par_det;
   assign abil_ok = ability_valid(phy.eth_link, phy.serdes_direct, an_flag, an_done);
   // each partner ability lands on its own status bit, lsb at bit 09
   assign abil_out = abil_ok ? phy.ability : 6'h00;

   // unqualified abilities are forced to zero so readers never see stale data
   always_comb
   begin
      word_d = WORD_RST;
      word_d[AN_FLAG_BIT] = an_flag;
      word_d[AN_DONE_BIT] = an_done;
      word_d[PAR_DET_BIT] = par_det;
      word_d[RSVD_BIT] = 1'b0;
      word_d[ABIL_HI_BIT:ABIL_LO_BIT] = abil_out;
      word_d[SERDES_BIT] = phy.serdes_direct;
   end

   // one register stage samples the whole word at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         word_q <= WORD_RST;
      else
         word_q <= word_d;
   end

endmodule : link_status_word

// [link_partner_status_bits.sv]
// link status bits 05..14 and 20 with apb access and a sideband snapshot
// assumes apb master on pclk; phy state synchronous to pclk

module link_partner_status_bits
   import link_status_pkg::*;
#(
   parameter int ADDR_W = 8 // apb address width
)
(
   input wire logic pclk, // controller clock, 50 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire phy_state_s phy, // phy and negotiation state
   input wire logic status_req, // sideband link status request pulse
   output logic [31:0] status_word, // snapshot returned to sideband
   output logic status_valid // snapshot fresh, the request delayed by one cycle
);

   // ------------------------------------------------------------
   // status word builder
   // ------------------------------------------------------------
   logic ctrl_an_en_q;
   logic [31:0] word_q;

   // software enable steers the negotiation flag
   link_status_word u_word (
      .pclk(pclk),
      .presetn(presetn),
      .phy(phy),
      .an_en(ctrl_an_en_q),
      .word_q(word_q)
   );

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic [7:0] addr8;
   logic hit_ctrl;
   logic hit_live;
   logic hit_snap;
   logic hit_raw;
   logic hit_any;
   logic setup;
   logic access;
   logic wr_ctrl;

   // low byte of the address selects the word
   assign addr8 = 8'(paddr);
   assign hit_ctrl = (addr8 == CTRL_OFF);
   assign hit_live = (addr8 == LIVE_OFF);
   assign hit_snap = (addr8 == SNAP_OFF);
   assign hit_raw = (addr8 == RAW_OFF);
   assign hit_any = hit_ctrl | hit_live | hit_snap | hit_raw;

   // phases of one transfer
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_ctrl = access & pwrite & hit_ctrl;

   // read data is fetched in setup, so access never waits
   assign pready = 1'b1;
   assign pslverr = access & ~hit_any;

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   // only the enable bit is stored, the rest reads as zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_an_en_q <= CTRL_AN_EN_RST;
      else if (wr_ctrl)
         ctrl_an_en_q <= pwdata[CTRL_AN_EN_BIT];
   end

   // ------------------------------------------------------------
   // sideband snapshot
   // ------------------------------------------------------------
   logic [31:0] snap_q;
   logic snap_vld_q;

   // the request freezes the word so a slow reader sees one consistent set
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         snap_q <= WORD_RST;
      else if (status_req)
         snap_q <= word_q;
   end

   // fresh pulse one cycle after the request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         snap_vld_q <= 1'b0;
      else
         snap_vld_q <= status_req;
   end

   assign status_word = snap_q;
   assign status_valid = snap_vld_q;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   logic [31:0] ctrl_rd;
   logic [31:0] raw_rd;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;

   // raw view shows the unqualified abilities for debug
   assign ctrl_rd = {31'h0000_0000, ctrl_an_en_q};
   assign raw_rd = {26'h000_0000, phy.ability};
   assign rd_d = hit_ctrl ? ctrl_rd :
                 hit_live ? word_q :
                 hit_snap ? snap_q :
                 hit_raw ? raw_rd : 32'h0000_0000;

   // captured in setup; unmapped or write reads back zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (setup)
         prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
   end

   assign prdata = prdata_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic past_ok;
   logic [1:0] seen_q;

   // $past is not trusted until three edges after reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         seen_q <= 2'h0;
      else if (seen_q != 2'h3)
         seen_q <= 2'(seen_q + 2'h1);
   end

   assign past_ok = (seen_q == 2'h3);

   logic exp_flag;
   logic exp_done;
   logic exp_abil_ok;

   // reference of what the word should be one cycle after the inputs
   assign exp_flag = phy.eth_link & phy.an_capable & ctrl_an_en_q;
   assign exp_done = exp_flag & (phy.an_done | phy.par_det);
   assign exp_abil_ok = ability_valid(phy.eth_link, phy.serdes_direct, exp_flag, exp_done);

   an_flag_a: assert property (past_ok |-> word_q[AN_FLAG_BIT] == $past(exp_flag))
      else $error("negotiation enabled bit wrong");

   an_done_a: assert property (past_ok && $past(exp_flag && (phy.an_done || phy.par_det))
                               |-> word_q[AN_DONE_BIT])
      else $error("negotiation done bit not set");

   an_zero_a: assert property ($past(!phy.eth_link || !phy.an_capable || !ctrl_an_en_q) && past_ok
                               |-> !word_q[AN_DONE_BIT])
      else $error("negotiation done bit set while unqualified");

   done_pair_a: assert property (word_q[AN_DONE_BIT] |-> word_q[AN_FLAG_BIT])
      else $error("done bit without enabled bit");

   par_set_a: assert property (past_ok && $past(phy.eth_link && phy.par_det)
                               |-> word_q[PAR_DET_BIT])
      else $error("parallel detection bit not set");

   par_clear_a: assert property (past_ok && $past(!phy.eth_link || !phy.par_det)
                                 |-> !word_q[PAR_DET_BIT])
      else $error("parallel detection bit set wrongly");

   abil_map_a: assert property (
      past_ok && $past(exp_abil_ok) |-> word_q[ABIL_HI_BIT:ABIL_LO_BIT] == $past(phy.ability))
      else $error("partner ability bits do not follow partner");

   abil_mask_a: assert property (past_ok && !$past(exp_abil_ok)
                                 |-> word_q[ABIL_HI_BIT:ABIL_LO_BIT] == 6'h00)
      else $error("partner ability bits leak while unqualified");

   rsvd_zero_a: assert property (!word_q[RSVD_BIT] && !snap_q[RSVD_BIT])
      else $error("reserved bit not zero");

   serdes_bit_a: assert property (past_ok |-> word_q[SERDES_BIT] == $past(phy.serdes_direct))
      else $error("serdes bit does not follow attach mode");

   snap_take_a: assert property (status_req |=> status_valid && status_word == $past(word_q))
      else $error("snapshot not taken on request");

   snap_hold_a: assert property (!status_req |=> !status_valid && $stable(status_word))
      else $error("snapshot changed without request");

   ctrl_write_a: assert property (wr_ctrl |=> ctrl_an_en_q == $past(pwdata[CTRL_AN_EN_BIT]))
      else $error("control write not taken");

   apb_read_a: assert property (setup && !pwrite && hit_live |=> prdata == $past(word_q))
      else $error("live read data wrong");

   apb_err_a: assert property (access |-> pslverr == !hit_any)
      else $error("error response wrong");

   // main scenarios
   neg_done_c: cover property (word_q[AN_DONE_BIT] && !word_q[PAR_DET_BIT]);
   par_link_c: cover property (word_q[AN_DONE_BIT] && word_q[PAR_DET_BIT]);
   gig_seen_c: cover property (status_valid && status_word[ABIL_LO_BIT]);
   an_off_c: cover property (wr_ctrl && !pwdata[CTRL_AN_EN_BIT] ##2 !word_q[AN_FLAG_BIT]);
   bad_addr_c: cover property (pslverr);

endmodule : link_partner_status_bits

// [mgmt_requester.sv]
// model of the sideband management reader that asks for link status
// assumes the block answers one pclk after each request pulse

module mgmt_requester
(
   input wire logic pclk, // controller clock
   input wire logic [31:0] status_word, // snapshot from the block
   output logic status_req, // request, held high for n cycles by ask
   output logic [5:0] usable_abil // abilities the reader may trust
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // request driver
   // ---------------------------------------------
   initial status_req = 1'b0;

   // n back-to-back requests; signals change just after an edge
   task automatic ask(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         status_req <= 1'b1;
      end
      @(posedge pclk);
      status_req <= 1'b0;
   endtask : ask

   // abilities are ignored unless negotiation finished on a copper link
   assign usable_abil = (status_word[5] & status_word[6] & ~status_word[20]) ? status_word[14:9] : 6'h00;
endmodule : mgmt_requester

// [link_partner_status_bits_tb_top.sv]
// self-checking bench for the link partner status bits block
// assumes zero wait apb answers and a registered sideband snapshot

module link_partner_status_bits_tb_top import link_status_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, status_req, status_valid, en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, status_word, e, snap_e;
   logic [5:0] usable_abil;
   phy_state_s phy, p;
   int n_fail, checks_done;
   logic [32:0] rq[$];
   logic [31:0] sq[$];

   link_partner_status_bits #(.ADDR_W(8)) link_partner_status_bits_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phy(phy), .status_req(status_req), .status_word(status_word),
      .status_valid(status_valid));
   mgmt_requester mgmt_requester_inst (.pclk(pclk), .status_word(status_word), .status_req(status_req),
      .usable_abil(usable_abil));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // word the block should hold for a given phy state and enable
   function automatic logic [31:0] expect_word(input phy_state_s q, input logic c);
      logic an, dn;
      an = q.eth_link & q.an_capable & c;
      dn = an & (q.an_done | q.par_det);
      expect_word = 32'h0;
      expect_word[5] = an;
      expect_word[6] = dn;
      expect_word[7] = q.eth_link & q.par_det;
      expect_word[14:9] = (q.eth_link & ~q.serdes_direct & dn) ? q.ability : 6'h00;
      expect_word[20] = q.serdes_direct;
   endfunction : expect_word

   task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one apb transfer; read expectations are queued for the monitor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
      if (!wr)
         rq.push_back(x);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic stop_test();
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // ---------------------------------------------
   // clock, monitor and watchdog
   // ---------------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // results are matched in arrival order against the oldest note
   always @(posedge pclk)
   begin
      if (presetn && psel && penable && pready && !pwrite)
         chk("apb read", rq.pop_front(), {pslverr, prdata});
      if (status_valid === 1'b1)
      begin
         snap_e = sq.pop_front();
         chk("snapshot", {1'b0, snap_e}, {1'b0, status_word});
         chk("usable abilities", {27'h0, snap_e[14:9]}, {27'h0, usable_abil});
      end
   end

   initial
   begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      stop_test();
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      phy = '0;
      n_fail = 0;
      checks_done = 0;
      void'($urandom(32'hFBDC04E8));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFF, 32'h0, 33'h0_0000_0001);
      apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
      // first six walk one ability through a qualified link, then random
      for (int i = 0; i < 40; i++)
      begin
         p = phy_state_s'(11'($urandom));
         if (i % 2 == 0)
         begin
            p.eth_link = 1'b1;
            p.an_capable = 1'b1;
            p.serdes_direct = 1'b0;
         end
         if (i < 6)
            p = {5'b11100, 6'(1 << i)};
         en = (i < 6) || ($urandom_range(1) == 1);
         phy <= p;
         e = expect_word(p, en);
         apb(1'b1, CTRL_OFF, {31'($urandom), en}, 33'h0);
         apb(1'b1, LIVE_OFF, $urandom, 33'h0);
         apb(1'b0, CTRL_OFF, 32'h0, {32'h0, en});
         apb(1'b0, LIVE_OFF, 32'h0, {1'b0, e});
         apb(1'b0, RAW_OFF, 32'h0, {27'h0, p.ability});
         sq.push_back(e);
         sq.push_back(e);
         mgmt_requester_inst.ask(2);
         apb(1'b0, SNAP_OFF, 32'h0, {1'b0, e});
      end
      // second reset in mid-run clears the snapshot and restores enable
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("snapshot after reset", 33'h0, {1'b0, status_word});
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFF, 32'h0, 33'h0_0000_0001);
      repeat (3) @(posedge pclk);
      chk("pending notes", 33'h0, 33'(rq.size() + sq.size()));
      stop_test();
   end
endmodule : link_partner_status_bits_tb_top
